// ---- pet_regs.sv ----
`timescale 1ns/1ns
`include "pet_defines.svh"

// Summary of operation
// - writing one to the constant-latency trigger selects constant latency
// - writing one to the low-power trigger selects low-power variable latency
// - each event register holds its flag in bit 0, readable and writable
// - flag set when the processor enters its sleep state
// - flag set when the processor leaves its sleep state
// - enable-set bit 0 enables the supply-failure interrupt, zero no effect
// - enable-set bit 1 enables the sleep-entry interrupt only
// - enable-set bit 2 enables the sleep-exit interrupt only
// - bank six power register exists only when that RAM slave exists
// - bank seven power register exists only when that RAM slave exists
// - bank six has set and clear registers acting on its power bits
// - bank seven has set and clear registers acting on its power bits
// - enable-clear register disables interrupts, same bit layout as set
module pet_regs (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // AHB-Lite slave port
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic hready_in,
    input wire logic [31:0] hwdata_in,
    output pet_pkg::pet_word_t hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    // event sources, asynchronous levels
    input wire logic supply_fail_warn_in,
    input wire logic cpu_sleeping_in,
    // block outputs
    output logic irq_out,
    output logic const_latency_out,
    output pet_pkg::pet_word_t bank6_power_out,
    output pet_pkg::pet_word_t bank7_power_out
);

    import pet_pkg::*;

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    pet_aphase_s wr_phase_q;
    pet_aphase_s rd_phase_q;
    pet_word_t rd_data_d;
    pet_word_t rd_data_q;
    pet_word_t bank6_q;
    pet_word_t bank7_q;
    pet_mode_e mode_q;
    pet_evt_t irq_en_q;
    pet_evt_t flags;
    pet_evt_t hw_set;
    pet_evt_t sw_wr;
    pet_evt_t sw_val;
    pet_evt_t w1c;
    logic [1:0] sync1_q;
    logic [1:0] sync2_q;
    logic [1:0] prev_q;
    logic ready_q;
    logic irq_q;
    logic accept;
    logic wr_now;
    logic [11:0] wr_addr;
    logic [11:0] rd_addr;

    // ------------------------------------------------------------
    // bus address phase
    // ------------------------------------------------------------
    // a transfer is taken on NONSEQ or SEQ while the bus is ready
    assign accept = hsel_in && htrans_in[1] && hready_in;
    assign wr_now = wr_phase_q.valid;
    assign wr_addr = wr_phase_q.addr;
    assign rd_addr = rd_phase_q.addr;

    // capture write address for use in the following data phase
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            wr_phase_q <= '0;
        end else begin
            wr_phase_q.valid <= accept && hwrite_in;
            wr_phase_q.addr <= haddr_in[11:0];
        end
    end

    // reads take one wait state so a preceding write lands first
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            rd_phase_q <= '0;
        end else if (accept && !hwrite_in) begin
            rd_phase_q.valid <= 1'b1;
            rd_phase_q.addr <= haddr_in[11:0];
        end else begin
            rd_phase_q.valid <= 1'b0;
        end
    end

    // hreadyout low for the first cycle of a read data phase
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            ready_q <= 1'b1;
        end else if (accept && !hwrite_in) begin
            ready_q <= 1'b0;
        end else begin
            ready_q <= 1'b1;
        end
    end

    // every transfer answers OKAY
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            hresp_out <= 1'b0;
        end else begin
            hresp_out <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // event inputs: two-stage synchronisers and edge detection
    // ------------------------------------------------------------
    // bit 0 supply warning, bit 1 processor sleep level
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            sync1_q <= 2'h0;
            sync2_q <= 2'h0;
            prev_q <= 2'h0;
        end else begin
            sync1_q <= {cpu_sleeping_in, supply_fail_warn_in};
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end

    // rising warning level is a detected supply failure
    assign hw_set[`PET_BIT_SUPPLY_FAIL] = sync2_q[0] && !prev_q[0];
    // sleep level rising is entry, falling is exit
    assign hw_set[`PET_BIT_SLEEP_ENTRY] = sync2_q[1] && !prev_q[1];
    assign hw_set[`PET_BIT_SLEEP_EXIT] = !sync2_q[1] && prev_q[1];

    // ------------------------------------------------------------
    // software access to the event flags
    // ------------------------------------------------------------
    // direct writes store bit 0 of the written word
    assign sw_wr[0] = wr_now && (wr_addr == `PET_OFS_SUPPLY_FAIL_FLAG);
    assign sw_wr[1] = wr_now && (wr_addr == `PET_OFS_SLEEP_ENTRY_FLAG);
    assign sw_wr[2] = wr_now && (wr_addr == `PET_OFS_SLEEP_EXIT_FLAG);
    assign sw_val = {3{hwdata_in[`PET_BIT_FLAG]}};

    // status register clears flags written with one
    always_comb begin
        w1c = 3'h0;
        if (wr_now && (wr_addr == `PET_OFS_IRQ_STATUS)) begin
            w1c = hwdata_in[2:0];
        end
    end

    // one sticky flag per event
    genvar gi;
    generate
        for (gi = 0; gi < `PET_NUM_EVENTS; gi = gi + 1) begin : g_flag
            pet_event_flag u_flag (
                .sys_clk_in(sys_clk_in),
                .rst_n_in(rst_n_in),
                .hw_set_in(hw_set[gi]),
                .sw_wr_in(sw_wr[gi]),
                .sw_val_in(sw_val[gi]),
                .w1c_in(w1c[gi]),
                .flag_out(flags[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // interrupt enables and output
    // ------------------------------------------------------------
    // set and clear registers act only on bits written as one
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            irq_en_q <= `PET_IRQ_EN_RST;
        end else if (wr_now && (wr_addr == `PET_OFS_IRQ_EN_SET)) begin
            irq_en_q[`PET_BIT_SUPPLY_FAIL] <= irq_en_q[0] | hwdata_in[0];
            irq_en_q[`PET_BIT_SLEEP_ENTRY] <= irq_en_q[1] | hwdata_in[1];
            irq_en_q[`PET_BIT_SLEEP_EXIT] <= irq_en_q[2] | hwdata_in[2];
        end else if (wr_now && (wr_addr == `PET_OFS_IRQ_EN_CLR)) begin
            irq_en_q <= irq_en_q & ~hwdata_in[2:0];
        end
    end

    // level interrupt, one cycle behind the flags
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(flags & irq_en_q);
        end
    end

    // ------------------------------------------------------------
    // latency mode
    // ------------------------------------------------------------
    // triggers store nothing; the last one written with one wins
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            mode_q <= PET_MODE_LOW_POWER;
        end else if (wr_now && (wr_addr == `PET_OFS_CONST_LAT_TRIG)
                     && hwdata_in[`PET_BIT_TRIGGER]) begin
            mode_q <= PET_MODE_CONST_LAT;
        end else if (wr_now && (wr_addr == `PET_OFS_LOW_PWR_TRIG)
                     && hwdata_in[`PET_BIT_TRIGGER]) begin
            mode_q <= PET_MODE_LOW_POWER;
        end
    end

    // ------------------------------------------------------------
    // RAM bank power control
    // ------------------------------------------------------------
    // bank six: direct, set and clear access, only when present
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            bank6_q <= `PET_BANK_POWER_RST;
        end else if (wr_now && `PET_BANK6_PRESENT) begin
            case (wr_addr)
                `PET_OFS_BANK6_POWER: begin
                    bank6_q <= hwdata_in;
                end
                `PET_OFS_BANK6_SET: begin
                    bank6_q <= bank6_q | hwdata_in;
                end
                `PET_OFS_BANK6_CLR: begin
                    bank6_q <= bank6_q & ~hwdata_in;
                end
                default: begin
                    bank6_q <= bank6_q;
                end
            endcase
        end
    end

    // bank seven: same layout at its own offsets
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            bank7_q <= `PET_BANK_POWER_RST;
        end else if (wr_now && `PET_BANK7_PRESENT) begin
            case (wr_addr)
                `PET_OFS_BANK7_POWER: begin
                    bank7_q <= hwdata_in;
                end
                `PET_OFS_BANK7_SET: begin
                    bank7_q <= bank7_q | hwdata_in;
                end
                `PET_OFS_BANK7_CLR: begin
                    bank7_q <= bank7_q & ~hwdata_in;
                end
                default: begin
                    bank7_q <= bank7_q;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    // triggers and unmapped offsets read as zero
    always_comb begin
        rd_data_d = `PET_ZERO_WORD;
        case (rd_addr)
            `PET_OFS_SUPPLY_FAIL_FLAG: begin
                rd_data_d[`PET_BIT_FLAG] = flags[0];
            end
            `PET_OFS_SLEEP_ENTRY_FLAG: begin
                rd_data_d[`PET_BIT_FLAG] = flags[1];
            end
            `PET_OFS_SLEEP_EXIT_FLAG: begin
                rd_data_d[`PET_BIT_FLAG] = flags[2];
            end
            `PET_OFS_IRQ_EN_SET, `PET_OFS_IRQ_EN_CLR: begin
                rd_data_d[2:0] = irq_en_q;
            end
            `PET_OFS_IRQ_STATUS: begin
                rd_data_d[2:0] = flags;
            end
            `PET_OFS_BANK6_POWER, `PET_OFS_BANK6_SET,
            `PET_OFS_BANK6_CLR: begin
                if (`PET_BANK6_PRESENT) begin
                    rd_data_d = bank6_q;
                end
            end
            `PET_OFS_BANK7_POWER, `PET_OFS_BANK7_SET,
            `PET_OFS_BANK7_CLR: begin
                if (`PET_BANK7_PRESENT) begin
                    rd_data_d = bank7_q;
                end
            end
            default: begin
                rd_data_d = `PET_ZERO_WORD;
            end
        endcase
    end

    // read word registered during the wait state
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            rd_data_q <= `PET_ZERO_WORD;
        end else if (rd_phase_q.valid) begin
            rd_data_q <= rd_data_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // all outputs come straight from flops
    assign hrdata_out = rd_data_q;
    assign hreadyout_out = ready_q;
    assign irq_out = irq_q;
    assign const_latency_out = (mode_q == PET_MODE_CONST_LAT);
    assign bank6_power_out = bank6_q;
    assign bank7_power_out = bank7_q;

endmodule // pet_regs

// ---- pet_defines.svh ----
`ifndef PET_DEFINES_SVH
`define PET_DEFINES_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define PET_OFS_CONST_LAT_TRIG 12'h078
`define PET_OFS_LOW_PWR_TRIG 12'h07C
`define PET_OFS_SUPPLY_FAIL_FLAG 12'h108
`define PET_OFS_SLEEP_ENTRY_FLAG 12'h114
`define PET_OFS_SLEEP_EXIT_FLAG 12'h118
`define PET_OFS_IRQ_EN_SET 12'h304
`define PET_OFS_IRQ_EN_CLR 12'h308
`define PET_OFS_IRQ_STATUS 12'h30C
`define PET_OFS_BANK6_POWER 12'h960
`define PET_OFS_BANK6_SET 12'h964
`define PET_OFS_BANK6_CLR 12'h968
`define PET_OFS_BANK7_POWER 12'h970
`define PET_OFS_BANK7_SET 12'h974
`define PET_OFS_BANK7_CLR 12'h978

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PET_BIT_TRIGGER 0
`define PET_BIT_FLAG 0
`define PET_BIT_SUPPLY_FAIL 0
`define PET_BIT_SLEEP_ENTRY 1
`define PET_BIT_SLEEP_EXIT 2
`define PET_NUM_EVENTS 3

// ----------------------------------------------------------------
// reset values and build options
// ----------------------------------------------------------------
`define PET_IRQ_EN_RST 3'h0
`define PET_BANK_POWER_RST 32'h0000_0000
`define PET_BANK6_PRESENT 1'b1
`define PET_BANK7_PRESENT 1'b1
`define PET_ZERO_WORD 32'h0000_0000

`endif

// ---- pet_pkg.sv ----
package pet_pkg;

    // latency mode selected by the two triggers
    typedef enum logic {
        PET_MODE_LOW_POWER,
        PET_MODE_CONST_LAT
    } pet_mode_e;

    // one captured bus address phase
    typedef struct packed {
        logic valid;
        logic [11:0] addr;
    } pet_aphase_s;

    // one bank power control word
    typedef logic [31:0] pet_word_t;

    // event flags and enables, bit order as in the enable registers
    typedef logic [2:0] pet_evt_t;

endpackage

// ---- pet_event_flag.sv ----
`timescale 1ns/1ns
// sticky event flag: hardware set wins over any software write
module pet_event_flag (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic hw_set_in,
    input wire logic sw_wr_in,
    input wire logic sw_val_in,
    input wire logic w1c_in,
    output logic flag_out
);

    // ------------------------------------------------------------
    // flag storage
    // ------------------------------------------------------------
    // priority: event, then write-one-clear, then direct write
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            flag_out <= 1'b0;
        end else if (hw_set_in) begin
            flag_out <= 1'b1;
        end else if (w1c_in) begin
            flag_out <= 1'b0;
        end else if (sw_wr_in) begin
            flag_out <= sw_val_in;
        end
    end

endmodule // pet_event_flag

// ---- pet_regs_asserts.sv ----
`timescale 1ns/1ns
// --------------------------------------------------------------
// port checker for the power event register bank
// --------------------------------------------------------------
module pet_regs_asserts (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic hready_in,
    input wire logic [31:0] hwdata_in,
    input wire pet_pkg::pet_word_t hrdata_out,
    input wire logic hreadyout_out,
    input wire logic irq_out,
    input wire logic const_latency_out,
    input wire pet_pkg::pet_word_t bank6_power_out,
    input wire pet_pkg::pet_word_t bank7_power_out
);
    import pet_pkg::*;
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);
    logic tk;
    logic wr;
    logic rd;
    logic [11:0] a;
    // transfer taken on this edge, split by direction
    assign tk = hsel_in && htrans_in[1] && hready_in;
    assign wr = tk && hwrite_in;
    assign rd = tk && !hwrite_in;
    assign a = haddr_in[11:0];

    a_read_wait: assert property (
        rd |=> !hreadyout_out ##1 hreadyout_out)
        else $error("read wait state wrong");
    a_write_nowait: assert property (
        wr |=> hreadyout_out)
        else $error("write stalled");
    a_const_mode: assert property (
        wr && a == 12'h078 ##1 hwdata_in[0] |=> const_latency_out)
        else $error("constant latency not selected");
    a_lowpwr_mode: assert property (
        wr && a == 12'h07C ##1 hwdata_in[0] |=> !const_latency_out)
        else $error("low power not selected");
    a_mode_cause: assert property (
        $changed(const_latency_out) |-> $past(wr, 2) &&
        ($past(a, 2) == 12'h078 || $past(a, 2) == 12'h07C))
        else $error("mode changed without trigger");
    a_bank6_set: assert property (
        wr && a == 12'h964 ##1 1'b1 |=> bank6_power_out ==
        ($past(bank6_power_out) | $past(hwdata_in)))
        else $error("bank6 set wrong");
    a_bank6_clear: assert property (
        wr && a == 12'h968 ##1 1'b1 |=> bank6_power_out ==
        ($past(bank6_power_out) & ~$past(hwdata_in)))
        else $error("bank6 clear wrong");
    a_bank7_set: assert property (
        wr && a == 12'h974 ##1 1'b1 |=> bank7_power_out ==
        ($past(bank7_power_out) | $past(hwdata_in)))
        else $error("bank7 set wrong");
    a_bank7_clear: assert property (
        wr && a == 12'h978 ##1 1'b1 |=> bank7_power_out ==
        ($past(bank7_power_out) & ~$past(hwdata_in)))
        else $error("bank7 clear wrong");
    a_trig_reads_zero: assert property (
        rd && (a == 12'h078 || a == 12'h07C) |=> ##1
        hrdata_out == 32'h0000_0000)
        else $error("trigger read not zero");
    a_irq_fall: assert property (
        $fell(irq_out) |-> $past(wr, 2) || $past(wr, 3))
        else $error("irq dropped without write");
    c_read: cover property (rd);
    c_irq: cover property ($rose(irq_out));
    c_mode: cover property ($rose(const_latency_out));
endmodule // pet_regs_asserts

bind pet_regs pet_regs_asserts u_chk (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .hsel_in(hsel_in),
    .haddr_in(haddr_in),
    .htrans_in(htrans_in),
    .hwrite_in(hwrite_in),
    .hready_in(hready_in),
    .hwdata_in(hwdata_in),
    .hrdata_out(hrdata_out),
    .hreadyout_out(hreadyout_out),
    .irq_out(irq_out),
    .const_latency_out(const_latency_out),
    .bank6_power_out(bank6_power_out),
    .bank7_power_out(bank7_power_out)
);

// ---- pet_regs_bench.sv ----
`timescale 1ns/1ns
module pet_regs_bench;
    import pet_pkg::*;
    logic clk, rst_n, hsel, hwrite, sfw, slp, hrdy, hresp, irq, cl;
    logic [31:0] haddr, hwdata;
    logic [1:0] htrans;
    logic [11:0] ba;
    pet_word_t hrdata, b6, b7, rv;
    int bad_count, n_checks;

    pet_regs dut (
        .sys_clk_in(clk), .rst_n_in(rst_n), .hsel_in(hsel),
        .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
        .hsize_in(3'h2), .hready_in(hrdy), .hwdata_in(hwdata),
        .hrdata_out(hrdata), .hreadyout_out(hrdy), .hresp_out(hresp),
        .supply_fail_warn_in(sfw), .cpu_sleeping_in(slp),
        .irq_out(irq), .const_latency_out(cl),
        .bank6_power_out(b6), .bank7_power_out(b7)
    );

    // one single word transfer, entered right after a rising edge
    task automatic bus(input logic w, input logic [11:0] a,
                       input pet_word_t d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {20'h0_0000, a};
        do @(posedge clk); while (hrdy !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk); while (hrdy !== 1'b1);
        rv = hrdata;
    endtask

    // compare and count
    task automatic chk(input string n, input pet_word_t e,
                       input pet_word_t g);
        n_checks++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", n, e, g);
            bad_count++;
        end
    endtask

    // read a register and compare
    task automatic rdc(input logic [11:0] a, input pet_word_t e);
        bus(1'b0, a, 32'h0000_0000);
        chk($sformatf("reg %h", a), e, rv);
    endtask

    // verdict and end of run
    task test_done;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // hang guard
    initial begin
        #400000;
        bad_count++;
        test_done;
    end

    // main sequence
    initial begin
        {rst_n, hsel, hwrite, sfw, slp} = 5'h00;
        haddr = 32'h0000_0000;
        hwdata = 32'h0000_0000;
        htrans = 2'b00;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        chk("mode", 32'h0000_0000, cl);
        chk("bank6", 32'h0000_0000, b6);
        rdc(12'h304, 32'h0000_0000);
        bus(1'b1, 12'h078, 32'h0000_0001);
        rdc(12'h078, 32'h0000_0000);
        chk("mode", 32'h0000_0001, cl);
        bus(1'b1, 12'h07C, 32'h0000_0000);
        rdc(12'h07C, 32'h0000_0000);
        chk("mode", 32'h0000_0001, cl);
        bus(1'b1, 12'h07C, 32'h0000_0001);
        rdc(12'h200, 32'h0000_0000);
        chk("mode", 32'h0000_0000, cl);
        bus(1'b1, 12'h304, 32'h0000_0001);
        rdc(12'h304, 32'h0000_0001);
        bus(1'b1, 12'h304, 32'h0000_0000);
        rdc(12'h304, 32'h0000_0001);
        bus(1'b1, 12'h304, 32'h0000_0002);
        rdc(12'h304, 32'h0000_0003);
        bus(1'b1, 12'h304, 32'h0000_0004);
        rdc(12'h304, 32'h0000_0007);
        bus(1'b1, 12'h308, 32'h0000_0002);
        rdc(12'h308, 32'h0000_0005);
        sfw <= 1'b1;
        repeat (6) @(posedge clk);
        chk("irq", 32'h0000_0001, irq);
        rdc(12'h108, 32'h0000_0001);
        bus(1'b1, 12'h108, 32'h0000_0000);
        repeat (3) @(posedge clk);
        chk("irq", 32'h0000_0000, irq);
        rdc(12'h108, 32'h0000_0000);
        slp <= 1'b1;
        repeat (6) @(posedge clk);
        rdc(12'h114, 32'h0000_0001);
        chk("irq", 32'h0000_0000, irq);
        slp <= 1'b0;
        repeat (6) @(posedge clk);
        rdc(12'h118, 32'h0000_0001);
        chk("irq", 32'h0000_0001, irq);
        // status word: entry and exit flags up, supply flag cleared
        rdc(12'h30C, 32'h0000_0006);
        bus(1'b1, 12'h30C, 32'h0000_0007);
        repeat (3) @(posedge clk);
        chk("irq", 32'h0000_0000, irq);
        rdc(12'h114, 32'h0000_0000);
        bus(1'b1, 12'h118, 32'h0000_0001);
        rdc(12'h118, 32'h0000_0001);
        bus(1'b1, 12'h308, 32'h0000_0007);
        rdc(12'h304, 32'h0000_0000);
        repeat (3) @(posedge clk);
        chk("irq", 32'h0000_0000, irq);
        // both banks: plain write, set ones, clear ones
        for (int i = 0; i < 2; i++) begin
            ba = 12'h960 + (i[11:0] << 4);
            bus(1'b1, ba, 32'hA5A5_0F0F);
            rdc(ba, 32'hA5A5_0F0F);
            bus(1'b1, ba + 12'h004, 32'h0000_F0F0);
            rdc(ba + 12'h004, 32'hA5A5_FFFF);
            bus(1'b1, ba + 12'h008, 32'h0505_00F0);
            rdc(ba + 12'h008, 32'hA0A0_FF0F);
            chk("bank port", 32'hA0A0_FF0F, i ? b7 : b6);
        end
        bus(1'b1, 12'h200, 32'hFFFF_FFFF);
        rdc(12'h200, 32'h0000_0000);
        chk("bank6 kept", 32'hA0A0_FF0F, b6);
        chk("bank7 kept", 32'hA0A0_FF0F, b7);
        chk("resp", 32'h0000_0000, hresp);
        test_done;
    end
endmodule // pet_regs_bench
